// file: core/asr_pkg.sv
// Package: register map, control layout and framing constants for the receiver
package asr_pkg;

	// ****************************************************
	// Register map
	// ****************************************************
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_SAMPLE = 12'h008;

	// ****************************************************
	// Control fields
	// ****************************************************
	typedef enum logic [1:0] {FMT_STD, FMT_LJ, FMT_RJ} asr_fmt_t;
	typedef enum logic [1:0] {SLOT_16, SLOT_24, SLOT_32} asr_slot_t;
	typedef enum logic [1:0] {WID_16, WID_20, WID_24, WID_32} asr_wid_t;
	typedef enum logic [1:0] {CH_LEFT, CH_RIGHT, CH_AVG} asr_ch_t;

	// Packed low to high: enable[0] fmt[2:1] tdm[3] slot[5:4] wid[7:6] ch[9:8]
	typedef struct packed {
		asr_ch_t channel_source_select;
		asr_wid_t widthSel;
		asr_slot_t slotSel;
		logic tdm;
		asr_fmt_t fmt;
		logic enable;
	} asr_ctrl_t;

	localparam int CTRL_W = $bits(asr_ctrl_t);
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h0;

	// ****************************************************
	// Framing constants
	// ****************************************************
	localparam logic [5:0] LEN_16 = 6'h10;
	localparam logic [5:0] LEN_20 = 6'h14;
	localparam logic [5:0] LEN_24 = 6'h18;
	localparam logic [5:0] LEN_32 = 6'h20;
	localparam logic [1:0] LAST_SLOT_STEREO = 2'h1;
	localparam logic [1:0] LAST_SLOT_TDM = 2'h3;
	localparam int SYNC_W = 3;

	// Synchroniser state
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} asr_sync_t;

	// Slot length in bit clocks; the spare code falls back to 32
	function automatic logic [5:0] asr_slot_len(input asr_slot_t s);
		unique case (s)
			SLOT_16: asr_slot_len = LEN_16;
			SLOT_24: asr_slot_len = LEN_24;
			default: asr_slot_len = LEN_32;
		endcase
	endfunction : asr_slot_len

	function automatic logic [5:0] asr_width(input asr_wid_t w);
		unique case (w)
			WID_16: asr_width = LEN_16;
			WID_20: asr_width = LEN_20;
			WID_24: asr_width = LEN_24;
			WID_32: asr_width = LEN_32;
		endcase
	endfunction : asr_width

endpackage : asr_pkg

// file: core/asr_sync.sv
// Two-flop synchroniser for the serial link pins
`timescale 1ns/10ps
module asr_sync
	import asr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [SYNC_W-1:0] din,
	output logic [SYNC_W-1:0] dout
);

	asr_sync_t s_q;
	asr_sync_t s_d;

	// First stage feeds only the second
	always_comb begin
		s_d.s1 = din;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.s2;

endmodule : asr_sync

// file: core/asr_rx.sv
// Slave serial audio receiver: two-slot or four-slot deframer with APB registers
`timescale 1ns/10ps
module asr_rx
	import asr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serialBitClock,
	input wire logic frameSync,
	input wire logic serialDataIn,
	output logic [31:0] sampleOut,
	output logic sampleValid,
	output logic frameActive
);

	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		logic bclkPrev;
		logic fsPrev;
		logic pend;
		logic run;
		logic [5:0] bitCnt;
		logic [1:0] slot;
		logic [31:0] shift;
		logic [31:0] leftWord;
		logic [31:0] rightWord;
		logic [31:0] sample;
		logic sampleValid;
		logic [15:0] frameCnt;
		asr_ctrl_t ctrl;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} asr_state_t;

	asr_state_t s_q;
	asr_state_t s_d;
	logic [SYNC_W-1:0] pinSync;
	logic bclkS;
	logic fsS;
	logic dataS;
	logic bclkRise;
	logic fsRise;
	logic fsFall;
	logic frameStart;
	logic capBit;
	logic inWin;
	logic [5:0] slotLen;
	logic [5:0] width;
	logic [5:0] useW;
	logic [1:0] lastSlot;
	logic [31:0] shIn;
	logic [31:0] shNew;
	logic [31:0] word;
	logic signed [32:0] sum;

	// ****************************************************
	// Pin capture
	// ****************************************************
	// Bit clock is oversampled, so all three pins share one latency
	asr_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din({serialBitClock, frameSync, serialDataIn}),
		.dout(pinSync)
	);

	assign {bclkS, fsS, dataS} = pinSync;

	// Edge events seen on the bit clock
	assign bclkRise = bclkS && !s_q.bclkPrev;
	assign fsRise = bclkRise && !s_q.fsPrev && fsS;
	assign fsFall = bclkRise && s_q.fsPrev && !fsS;
	// Multi-slot always keys on the rise so either pulse width works
	assign frameStart = (s_q.ctrl.tdm || s_q.ctrl.fmt != FMT_STD) ?
		fsRise : fsFall;
	assign slotLen = asr_slot_len(s_q.ctrl.slotSel);
	assign width = asr_width(s_q.ctrl.widthSel);
	// A slot shorter than the sample keeps only its leading bits
	assign useW = (width > slotLen) ? slotLen : width;
	assign lastSlot = s_q.ctrl.tdm ? LAST_SLOT_TDM :
		LAST_SLOT_STEREO;

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		s_d = s_q;
		capBit = 1'b0;
		inWin = 1'b0;
		shIn = '0;
		shNew = '0;
		word = '0;
		sum = '0;
		s_d.sampleValid = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.bclkPrev = bclkS;

		// APB write lands only in the completing access cycle
		if (psel && penable && s_q.pready && pwrite &&
			paddr == OFF_CTRL) begin
			s_d.ctrl = asr_ctrl_t'(pwdata[CTRL_W-1:0]);
		end
		// Read data prepared in setup so the answer comes from flops
		if (psel && !penable) begin
			s_d.pready = 1'b1;
			s_d.prdata = '0;
			unique case (paddr)
				OFF_CTRL: s_d.prdata = {22'h0, s_q.ctrl};
				OFF_STATUS: s_d.prdata = {s_q.frameCnt, 15'h0, s_q.run};
				OFF_SAMPLE: s_d.prdata = s_q.sample;
				default: s_d.pslverr = 1'b1;
			endcase
		end

		// Deframer: all work happens on a bit-clock rise
		if (bclkRise) begin
			s_d.fsPrev = fsS;
			if (!s_q.ctrl.enable) begin
				s_d.run = 1'b0;
			end else if (frameStart) begin
				// Standard format spends one bit clock before the MSB
				s_d.bitCnt = '0;
				s_d.slot = '0;
				s_d.run = 1'b1;
				s_d.pend = (s_q.ctrl.fmt == FMT_STD);
				capBit = (s_q.ctrl.fmt != FMT_STD);
			end else if (s_q.run) begin
				if (s_q.pend) begin
					s_d.pend = 1'b0;
				end else if (s_q.bitCnt == slotLen - 6'h01) begin
					s_d.bitCnt = '0;
					s_d.slot = s_q.slot + 2'h1;
				end else begin
					s_d.bitCnt = s_q.bitCnt + 6'h01;
				end
				capBit = 1'b1;
			end
			if (capBit) begin
				// Right-justified data fills the tail of the slot
				if (s_q.ctrl.fmt == FMT_RJ) begin
					inWin = ({1'b0, s_d.bitCnt} + {1'b0, useW}) >=
						{1'b0, slotLen};
				end else begin
					inWin = s_d.bitCnt < width;
				end
				shIn = (s_d.bitCnt == 6'h00) ? 32'h00000000 : s_q.shift;
				shNew = inWin ? {shIn[30:0], dataS} : shIn;
				s_d.shift = shNew;
				if (s_d.bitCnt == slotLen - 6'h01) begin
					// Left-align so every width reads as a signed word
					word = shNew << (LEN_32 - useW);
					if (s_d.slot == 2'h0) begin
						s_d.leftWord = word;
					end
					if (s_d.slot == 2'h1) begin
						s_d.rightWord = word;
						sum = {s_q.leftWord[31], s_q.leftWord} +
							{word[31], word};
						unique case (s_q.ctrl.channel_source_select)
							CH_RIGHT: s_d.sample = word;
							CH_AVG: s_d.sample = sum[32:1];
							default: s_d.sample = s_q.leftWord;
						endcase
						s_d.sampleValid = 1'b1;
						s_d.frameCnt = s_q.frameCnt + 16'h0001;
					end
					// Wait for the next frame sync after the last slot
					if (s_d.slot == lastSlot) begin
						s_d.run = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.ctrl <= asr_ctrl_t'(CTRL_RST);
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign sampleOut = s_q.sample;
	assign sampleValid = s_q.sampleValid;
	assign frameActive = s_q.run;

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_std_start: assert property (
		(fsFall && s_q.ctrl.enable && !s_q.ctrl.tdm &&
		s_q.ctrl.fmt == FMT_STD) |=>
		(s_q.pend && s_q.run && s_q.bitCnt == 6'h00 && s_q.slot == 2'h0))
		else $error("standard frame start not taken on sync fall");

	a_lj_start: assert property (
		(fsRise && s_q.ctrl.enable && s_q.ctrl.fmt == FMT_LJ) |=>
		(!s_q.pend && s_q.run && s_q.bitCnt == 6'h00 && s_q.slot == 2'h0))
		else $error("left-justified start not on sync rise");

	a_rj_lead: assert property (
		(s_q.run && !s_q.pend && s_q.ctrl.fmt == FMT_RJ &&
		({1'b0, s_q.bitCnt} + {1'b0, width}) < {1'b0, slotLen}) |->
		s_q.shift == 32'h00000000)
		else $error("right-justified bits taken before window");

	a_tdm_start: assert property (
		(fsRise && s_q.ctrl.enable && s_q.ctrl.tdm) |=> s_q.run)
		else $error("multi-slot frame start missed");

	a_valid_slot: assert property (
		s_q.sampleValid |-> ($past(s_q.slot) == 2'h1 ||
		$past(s_q.bitCnt) == 6'h00))
		else $error("sample emitted outside right slot end");

	a_slot_wrap: assert property (
		(bclkRise && s_q.ctrl.enable && s_q.run && !frameStart &&
		!s_q.pend && s_q.bitCnt == slotLen - 6'h01) |=>
		(s_q.bitCnt == 6'h00 && s_q.slot == $past(s_q.slot) + 2'h1))
		else $error("slot did not wrap at slot length");

	a_width_stop: assert property (
		(bclkRise && s_q.ctrl.enable && s_q.run && !frameStart &&
		!s_q.pend && s_q.ctrl.fmt != FMT_RJ && s_q.bitCnt >= width &&
		s_q.bitCnt < slotLen - 6'h01) |=> $stable(s_q.shift))
		else $error("bits shifted beyond sample width");

	a_channel_source_select_left: assert property (
		(s_q.sampleValid && s_q.ctrl.channel_source_select == CH_LEFT) |->
		s_q.sample == s_q.leftWord)
		else $error("left source not selected");

	a_channel_source_select_right: assert property (
		(s_q.sampleValid && s_q.ctrl.channel_source_select == CH_RIGHT) |->
		s_q.sample == s_q.rightWord)
		else $error("right source not selected");

	a_bclk_only: assert property (
		(!bclkRise && $stable(s_q.ctrl)) |=> $stable(s_q.bitCnt))
		else $error("counter moved without a bit clock rise");

	c_std_sample: cover property (s_q.sampleValid &&
		s_q.ctrl.fmt == FMT_STD && !s_q.ctrl.tdm);
	c_tdm_sample: cover property (s_q.sampleValid && s_q.ctrl.tdm);
	c_rj_sample: cover property (s_q.sampleValid &&
		s_q.ctrl.fmt == FMT_RJ);
	c_avg_sample: cover property (s_q.sampleValid &&
		s_q.ctrl.channel_source_select == CH_AVG);

endmodule : asr_rx

// file: test/asr_host_model.sv
// Host audio master model: bit clock, frame sync and serial data
`timescale 1ns/10ps
module asr_host_model (
	output logic bitClk,
	output logic fSync,
	output logic sData
);
	// ****
	// Idle lines
	// ****
	// Bit clock stands still between frames
	initial begin
		bitClk = 1'b0;
		fSync = 1'b0;
		sData = 1'b0;
	end

	// One frame; lines change only while the bit clock is low
	task sendFrame(input int fmt, tdm, sh, len, wid,
		input logic [31:0] l, r);
		int d, k, q, p, s, off;
		logic [31:0] w;
		d = int'(fmt == 0);
		off = (wid > len) ? 0 : len - wid;
		#13;
		for (k = -1; k < (tdm ? 4 : 2) * len + d; k++) begin
			q = k - d;
			s = (q < 0) ? 9 : q / len;
			p = (q < 0) ? 0 : q % len;
			w = (s == 0) ? l : r;
			// Lead rise gives the receiver the level before the key edge
			if (fmt == 0 && tdm == 0)
				fSync = (k < 0 || k >= len);
			else if (tdm != 0 && sh != 0)
				fSync = (k == 0);
			else
				fSync = (k >= 0 && k < len);
			// Spare bits toggle so a stale line never looks valid
			if (s > 1)
				sData = ~sData;
			else if (fmt == 2)
				sData = (p >= off) ? w[31-(p-off)] : ~sData;
			else
				sData = (p < wid) ? w[31-p] : ~sData;
			#160 bitClk = 1'b1;
			#160 bitClk = 1'b0;
		end
		sData = ~sData;
	endtask : sendFrame
endmodule : asr_host_model

// file: test/test_audio_serial_slave_rx.sv
// Testbench: table of frames through the receiver, then edge cases
`timescale 1ns/10ps
module test_audio_serial_slave_rx
	import asr_pkg::*;
;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic bitClk, fSync, sData, sampleValid, frameActive;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, sampleOut, got, rd;
	asr_ctrl_t ctl;
	int n_errors = 0, n_compared = 0, nValid = 0, cyc = 0, i, n, v0;
	int nActive = 0, a0;
	localparam logic [31:0] LW = 32'hc3a5_96e1;
	localparam logic [31:0] RW = 32'h5a3c_e817;
	// Row: {expected sample, short sync pulse, control word}
	logic [42:0] rows [11] = '{{32'hc3a5_0000, 11'h001},
		{32'h5a3c_e817, 11'h1e1}, {32'h5a3c_0000, 11'h103},
		{32'hc3a5_9000, 11'h053}, {32'hc3a5_9600, 11'h0a5},
		{32'h5a3c_0000, 11'h185}, {32'h0ef1_3f7c, 11'h2e9},
		{32'hc3a5_0000, 11'h40b}, {32'h5a3c_0000, 11'h51d},
		{32'h0ef1_3f7c, 11'h2e3}, {32'hc3a5_0000, 11'h449}};

	asr_rx DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serialBitClock(bitClk),
		.frameSync(fSync), .serialDataIn(sData), .sampleOut(sampleOut),
		.sampleValid(sampleValid), .frameActive(frameActive));
	asr_host_model host (.bitClk(bitClk), .fSync(fSync), .sData(sData));

	// ****
	// Clock, capture, timeout
	// ****
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Pulse lasts one clock, so capture it here
	always @(posedge clk) begin
		if (sampleValid === 1'b1) begin
			got <= sampleOut;
			nValid <= nValid + 1;
		end
		// Busy cycles, so a frame must show up as active
		if (frameActive === 1'b1) begin
			nActive <= nActive + 1;
		end
	end

	// Whole run needs about 6000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			print_verdict();
		end
	end

	// ****
	// Tasks
	// ****
	task print_verdict();
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is seen
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// No fixed wait: only the bench timeout ends a stuck transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic int slen(input asr_ctrl_t c);
		return 16 + 8 * int'(c.slotSel);
	endfunction : slen

	function automatic int wlen(input asr_ctrl_t c);
		return (c.widthSel == WID_32) ? 32 : 16 + 4 * int'(c.widthSel);
	endfunction : wlen

	// ****
	// Main sequence
	// ****
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (7) @(posedge clk);
		chk(sampleOut | prdata | {28'h0, pready, pslverr, sampleValid,
			frameActive}, 32'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'(CTRL_RST));
		for (i = 0; i < 11; i++) begin
			ctl = rows[i][9:0];
			apb(1'b1, OFF_CTRL, {22'h0, ctl});
			v0 = nValid;
			a0 = nActive;
			host.sendFrame(ctl.fmt, ctl.tdm, rows[i][10], slen(ctl), wlen(ctl),
				LW, RW);
			for (n = 0; n < 40 && nValid == v0; n++)
				@(posedge clk);
			chk(got, rows[i][42:11]);
			chk(32'(nValid - v0), 32'h1);
			chk(32'(nActive > a0), 32'h1);
			chk({31'h0, frameActive}, 32'h0);
			apb(1'b0, OFF_SAMPLE, 32'h0);
			chk(rd, rows[i][42:11]);
		end
		// Status is read-only: a write is taken without error and ignored
		apb(1'b1, OFF_STATUS, 32'hffff_ffff);
		chk({31'h0, err}, 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd, 32'h000b_0000);
		// Unmapped write refused and leaves the control word alone
		apb(1'b1, 12'h00c, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk({rd[31:1], rd[0] ^ err}, 32'h1);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, {22'h0, rows[10][9:0]});
		// Disabled receiver must ignore a whole frame
		apb(1'b1, OFF_CTRL, 32'h2);
		v0 = nValid;
		a0 = nActive;
		host.sendFrame(1, 0, 0, 16, 16, LW, RW);
		repeat (40) @(posedge clk);
		chk(32'(nValid - v0), 32'h0);
		chk(32'(nActive - a0), 32'h0);
		// Mid-run reset returns outputs and registers to idle
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(sampleOut | prdata | {28'h0, pready, pslverr, sampleValid,
			frameActive}, 32'h0);
		rst_n <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'(CTRL_RST));
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd, 32'h0);
		print_verdict();
	end
endmodule : test_audio_serial_slave_rx
